// *** core/amp_reset_power_mute_ctrl.v ***
`timescale 1ns/1ps
`include "amp_ctrl_defines.vh"

// Operation
// - module reset resets filter, converters and core; module reset also clears coefficients
// - module reset self-clears; set only accepted while in standby or powerdown
// - register reset restores mode registers to reset values, self-clears
// - register reset keeps coefficient memory, switches program back to ROM
// - core reset bit resets to one; cleared releases core to run
// - standby request puts system in standby, charge pump and supply stay on
// - clock error also forces system standby
// - powerdown request shuts off charge pump too
// - powerdown wins over standby when both requested
// - left mute bit ramps left volume down, clearing ramps up
// - right mute bit ramps right volume down, clearing ramps up
module amp_reset_power_mute_ctrl #(
   parameter RESET_CYCLES = `MODULE_RESET_CYCLES,
   parameter SAMPLE_DIV   = `SAMPLE_DIV_CYCLES
) (
   // clock and reset
   input  wire       clk_sys,
   input  wire       rst,
   // register port
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata_q,
   // status from the device
   input  wire       clock_error,
   // subsystem controls
   output reg        filter_reset_q,
   output reg        converter_reset_q,
   output reg        core_reset_q,
   output reg        coef_clear_q,
   output reg        program_from_rom_q,
   output reg        standby_q,
   output reg        powerdown_q,
   output reg        charge_pump_on_q,
   output reg        digital_supply_on_q,
   output reg  [7:0] left_volume_q,
   output reg  [7:0] right_volume_q,
   output reg        left_muted_q,
   output reg        right_muted_q
);

   reg  [7:0]  power_q;
   reg  [7:0]  mute_q;
   reg         module_reset_q;
   reg         register_reset_q;
   reg  [7:0]  mrst_cnt_q;
   reg  [15:0] div_q;
   reg         tick_q;
   reg  [1:0]  pwr_state_d;
   wire [7:0]  lvol;
   wire [7:0]  rvol;
   wire        lmuted;
   wire        rmuted;
   wire        core_hold;
   wire        wr_reset;

   assign wr_reset  = reg_wr && reg_addr == `OFS_RESET_CONTROL;
   assign core_hold = power_q[`BIT_CORE_RESET] | module_reset_q;

   // power state: powerdown outranks standby, clock error forces standby
   always @* begin
      if (power_q[`BIT_POWERDOWN_REQUEST]) begin
         pwr_state_d = `PWR_POWERDOWN;
      end else if (power_q[`BIT_STANDBY_REQUEST] || clock_error) begin
         pwr_state_d = `PWR_STANDBY;
      end else begin
         pwr_state_d = `PWR_RUN;
      end
   end

   // sample-rate tick from the system clock
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         div_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else if (div_q == SAMPLE_DIV[15:0] - 16'h0001) begin
         div_q  <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

   // registers and self-clearing resets
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         power_q            <= `RST_POWER_STATE_CONTROL;
         mute_q             <= `RST_CHANNEL_MUTE_CONTROL;
         module_reset_q     <= 1'b0;
         register_reset_q   <= 1'b0;
         mrst_cnt_q         <= 8'h00;
         program_from_rom_q <= 1'b1;
      end else begin
         register_reset_q <= 1'b0;
         if (register_reset_q) begin
            // mode registers only; coefficient memory is not touched
            power_q            <= `RST_POWER_STATE_CONTROL;
            mute_q             <= `RST_CHANNEL_MUTE_CONTROL;
            program_from_rom_q <= 1'b1;
         end else if (reg_wr && reg_addr == `OFS_POWER_STATE_CONTROL) begin
            power_q <= reg_wdata & 8'h91;
         end else if (reg_wr && reg_addr == `OFS_CHANNEL_MUTE_CONTROL) begin
            mute_q <= reg_wdata & 8'h11;
         end
         // a write of zero does not cancel an active reset
         if (wr_reset && reg_wdata[`BIT_REGISTER_RESET]) begin
            register_reset_q <= 1'b1;
         end
         if (module_reset_q) begin
            if (mrst_cnt_q == RESET_CYCLES[7:0] - 8'h01) begin
               module_reset_q <= 1'b0;
               mrst_cnt_q     <= 8'h00;
            end else begin
               mrst_cnt_q <= mrst_cnt_q + 8'h01;
            end
         end else if (wr_reset && reg_wdata[`BIT_MODULE_RESET]
                      && pwr_state_d != `PWR_RUN) begin
            module_reset_q <= 1'b1;
            mrst_cnt_q     <= 8'h00;
         end
      end
   end

   volume_ramp #(.STEPS(`VOLUME_STEPS)) u_left (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .sample_tick (tick_q),
      .mute_req    (mute_q[`BIT_LEFT_MUTE_REQUEST]),
      .volume_q    (lvol),
      .muted_q     (lmuted)
   );

   volume_ramp #(.STEPS(`VOLUME_STEPS)) u_right (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .sample_tick (tick_q),
      .mute_req    (mute_q[`BIT_RIGHT_MUTE_REQUEST]),
      .volume_q    (rvol),
      .muted_q     (rmuted)
   );

   // registered outputs
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         filter_reset_q      <= 1'b1;
         converter_reset_q   <= 1'b1;
         core_reset_q        <= `RST_CORE_RESET;
         coef_clear_q        <= 1'b0;
         standby_q           <= 1'b0;
         powerdown_q         <= 1'b0;
         charge_pump_on_q    <= 1'b0;
         digital_supply_on_q <= 1'b0;
         left_volume_q       <= 8'h00;
         right_volume_q      <= 8'h00;
         left_muted_q        <= 1'b0;
         right_muted_q       <= 1'b0;
         reg_rdata_q         <= 8'h00;
      end else begin
         filter_reset_q      <= module_reset_q;
         converter_reset_q   <= module_reset_q;
         core_reset_q        <= core_hold;
         coef_clear_q        <= module_reset_q;
         standby_q           <= pwr_state_d == `PWR_STANDBY;
         powerdown_q         <= pwr_state_d == `PWR_POWERDOWN;
         charge_pump_on_q    <= pwr_state_d != `PWR_POWERDOWN;
         digital_supply_on_q <= pwr_state_d != `PWR_POWERDOWN;
         left_volume_q       <= lvol;
         right_volume_q      <= rvol;
         left_muted_q        <= lmuted;
         right_muted_q       <= rmuted;
         if (reg_rd) begin
            case (reg_addr)
               `OFS_RESET_CONTROL:
                  reg_rdata_q <= {3'h0, module_reset_q, 3'h0, register_reset_q};
               `OFS_POWER_STATE_CONTROL:
                  reg_rdata_q <= power_q;
               `OFS_CHANNEL_MUTE_CONTROL:
                  reg_rdata_q <= mute_q;
               default:
                  reg_rdata_q <= 8'h00;
            endcase
         end
      end
   end

endmodule

// *** core/amp_ctrl_defines.vh ***
`ifndef AMP_CTRL_DEFINES_VH
`define AMP_CTRL_DEFINES_VH

// register offsets
`define OFS_RESET_CONTROL        8'h01
`define OFS_POWER_STATE_CONTROL  8'h02
`define OFS_CHANNEL_MUTE_CONTROL 8'h03

// field positions
`define BIT_MODULE_RESET         4
`define BIT_REGISTER_RESET       0
`define BIT_CORE_RESET           7
`define BIT_STANDBY_REQUEST      4
`define BIT_POWERDOWN_REQUEST    0
`define BIT_LEFT_MUTE_REQUEST    4
`define BIT_RIGHT_MUTE_REQUEST   0

// reset values
`define RST_CORE_RESET           1'b1
`define RST_POWER_STATE_CONTROL  8'h80
`define RST_CHANNEL_MUTE_CONTROL 8'h00

// timing
`define MODULE_RESET_CYCLES      8'h10
`define VOLUME_STEPS             8'h80
// system clock cycles per audio sample
`define SAMPLE_DIV_CYCLES        16'h0341

// power states
`define PWR_RUN                  2'h0
`define PWR_STANDBY              2'h1
`define PWR_POWERDOWN            2'h2

`endif

// *** core/volume_ramp.v ***
`timescale 1ns/1ps
`include "amp_ctrl_defines.vh"

module volume_ramp #(
   parameter STEPS = `VOLUME_STEPS
) (
   // clock and reset
   input  wire       clk_sys,
   input  wire       rst,
   // control
   input  wire       sample_tick,
   input  wire       mute_req,
   // status
   output reg  [7:0] volume_q,
   output reg        muted_q
);

   // one step per sample keeps the ramp length fixed and pop-free
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         volume_q <= STEPS[7:0];
         muted_q  <= 1'b0;
      end else begin
         if (sample_tick) begin
            if (mute_req && volume_q != 8'h00) begin
               volume_q <= volume_q - 8'h01;
            end else if (!mute_req && volume_q != STEPS[7:0]) begin
               volume_q <= volume_q + 8'h01;
            end
         end
         muted_q <= (volume_q == 8'h00);
      end
   end

endmodule

// *** verif/amp_ctrl_asserts.sv ***
`timescale 1ns/1ps
module amp_ctrl_asserts #(
   parameter RESET_CYCLES = 8'h10,
   parameter SAMPLE_DIV   = 16'h0341
) (
   // clock and reset
   input wire       clk_sys,
   input wire       rst,
   // watched ports
   input wire       clock_error,
   input wire       filter_reset_q,
   input wire       core_reset_q,
   input wire       standby_q,
   input wire       powerdown_q,
   input wire       charge_pump_on_q,
   input wire [7:0] left_volume_q,
   input wire       left_muted_q,
   input wire       right_muted_q,
   input wire [7:0] right_volume_q
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_core; filter_reset_q |-> core_reset_q; endproperty
   a_core: assert property (p_core) else $error("core free in reset");
   property p_clr; $rose(filter_reset_q) |-> ##[1:40] !filter_reset_q; endproperty
   a_clr: assert property (p_clr) else $error("reset stuck");
   // state registered on the accepting edge is sampled one edge before the rise
   property p_stb; $rose(filter_reset_q) |-> $past(standby_q, 1) || $past(powerdown_q, 1);
   endproperty
   a_stb: assert property (p_stb) else $error("reset out of standby");
   property p_pd; powerdown_q |-> !standby_q && !charge_pump_on_q; endproperty
   a_pd: assert property (p_pd) else $error("bad powerdown");
   property p_sb; standby_q |-> charge_pump_on_q; endproperty
   a_sb: assert property (p_sb) else $error("pump off in standby");
   property p_err; clock_error [*3] |-> standby_q || powerdown_q; endproperty
   a_err: assert property (p_err) else $error("clock error ignored");
   property p_lm; $rose(left_muted_q) |-> left_volume_q == 8'h00; endproperty
   a_lm: assert property (p_lm) else $error("left muted early");
   property p_rm; $rose(right_muted_q) |-> right_volume_q == 8'h00; endproperty
   a_rm: assert property (p_rm) else $error("right muted early");
   property p_step; $changed(left_volume_q) && $past(left_volume_q) != 8'h00 |->
      left_volume_q == $past(left_volume_q) + 8'h01 ||
      left_volume_q == $past(left_volume_q) - 8'h01; endproperty
   a_step: assert property (p_step) else $error("ramp jump");
   c_mod: cover property ($rose(filter_reset_q));
   c_mute: cover property ($rose(left_muted_q));
   c_pd: cover property (powerdown_q);
endmodule
bind amp_reset_power_mute_ctrl amp_ctrl_asserts #(.RESET_CYCLES(RESET_CYCLES),
   .SAMPLE_DIV(SAMPLE_DIV)) chk_i (.clk_sys(clk_sys), .rst(rst), .clock_error(clock_error),
   .filter_reset_q(filter_reset_q), .core_reset_q(core_reset_q), .standby_q(standby_q),
   .powerdown_q(powerdown_q), .charge_pump_on_q(charge_pump_on_q),
   .left_volume_q(left_volume_q), .left_muted_q(left_muted_q),
   .right_muted_q(right_muted_q), .right_volume_q(right_volume_q));

// *** verif/host_model.sv ***
`timescale 1ns/1ps
module host_model (
   // clock
   input  wire       clk_sys,
   // register port
   output reg        reg_wr,
   output reg        reg_rd,
   output reg  [7:0] reg_addr,
   output reg  [7:0] reg_wdata,
   input  wire [7:0] reg_rdata_q
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   task wr(input [7:0] a, input [7:0] d); begin
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      // released address and data no longer carry the last value
      reg_addr = ~a;
      reg_wdata = ~d;
   end endtask
   task rd(input [7:0] a, output [7:0] d); begin
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata_q;
   end endtask
endmodule

// *** verif/tb_amp_reset_power_mute_ctrl.sv ***
`timescale 1ns/1ps
module tb_amp_reset_power_mute_ctrl;
   reg        clk_sys, rst, clock_error;
   wire       reg_wr, reg_rd, fr, cr, core, cc, rom, sb, pd, cp, ds, lm, rm;
   wire [7:0] reg_addr, reg_wdata, reg_rdata_q, lv, rv;
   integer    miscompares, tests_run, i;
   reg  [7:0] v;
   amp_reset_power_mute_ctrl #(.RESET_CYCLES(2), .SAMPLE_DIV(4)) uut (.clk_sys(clk_sys),
      .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .clock_error(clock_error),
      .filter_reset_q(fr), .converter_reset_q(cr), .core_reset_q(core), .coef_clear_q(cc),
      .program_from_rom_q(rom), .standby_q(sb), .powerdown_q(pd), .charge_pump_on_q(cp),
      .digital_supply_on_q(ds), .left_volume_q(lv), .right_volume_q(rv),
      .left_muted_q(lm), .right_muted_q(rm));
   host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));
   task chk(input [7:0] got, input [7:0] exp); begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   end endtask
   task rchk(input [7:0] a, input [7:0] e); begin
      host.rd(a, v);
      chk(v, e);
   end endtask
   task close_out; begin
      if (miscompares == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end endtask
   task pwr(input [7:0] d); begin
      host.wr(8'h02, d);
      repeat (3) @(negedge clk_sys);
      chk({4'h0, pd, sb, cp, ds}, {4'h0, d[0], d[4] & ~d[0], ~d[0], ~d[0]});
   end endtask
   task t_power; begin
      rchk(8'h02, 8'h80);
      rchk(8'h05, 8'h00);
      chk({7'h00, core}, 8'h01);
      pwr(8'h10);
      pwr(8'h01);
      pwr(8'h11);
      pwr(8'h00);
      chk({7'h00, core}, 8'h00);
      clock_error = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk({7'h00, sb}, 8'h01);
      clock_error = 1'b0;
   end endtask
   task t_mod; begin
      host.wr(8'h01, 8'h10);
      repeat (4) @(negedge clk_sys);
      chk({7'h00, fr}, 8'h00);
      host.wr(8'h02, 8'h10);
      host.wr(8'h01, 8'h10);
      for (i = 0; i < 8 && !fr; i = i + 1) @(negedge clk_sys);
      chk({4'h0, fr, cr, core, cc}, 8'h0f);
      for (i = 0; i < 40 && fr; i = i + 1) @(negedge clk_sys);
      chk({7'h00, fr}, 8'h00);
      rchk(8'h01, 8'h00);
   end endtask
   task t_reg; begin
      host.wr(8'h03, 8'h11);
      host.wr(8'h02, 8'h11);
      host.wr(8'h01, 8'h01);
      repeat (4) @(negedge clk_sys);
      rchk(8'h02, 8'h80);
      rchk(8'h03, 8'h00);
      rchk(8'h01, 8'h00);
      chk({7'h00, rom}, 8'h01);
   end endtask
   task t_mute; begin
      host.wr(8'h02, 8'h00);
      host.wr(8'h03, 8'h10);
      repeat (524) @(negedge clk_sys);
      chk(lv, 8'h00);
      chk({7'h00, lm}, 8'h01);
      chk(rv, 8'h80);
      chk({7'h00, rm}, 8'h00);
      host.wr(8'h03, 8'h01);
      repeat (524) @(negedge clk_sys);
      chk(rv, 8'h00);
      chk({7'h00, rm}, 8'h01);
      chk(lv, 8'h80);
      chk({7'h00, lm}, 8'h00);
   end endtask
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (6000) @(posedge clk_sys);
      miscompares = miscompares + 1;
      close_out;
   end
   initial begin
      rst = 1'b1;
      clock_error = 1'b0;
      miscompares = 0;
      tests_run = 0;
      repeat (12) @(negedge clk_sys);
      rst = 1'b0;
      t_power;
      t_mod;
      t_reg;
      t_mute;
      close_out;
   end
endmodule
